/* rtl/flash_seq.sv */
// Serial command handler for the security area and page maintenance jobs.
// Assumes pins arrive asynchronously; sck is slow against clk_sys.
`timescale 1ns/1ps
module flash_seq #(
    parameter logic [7:0] factory_id_seed = flash_seq_pkg::factory_seed,
    parameter bit binary_pages = 1'b0
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // Status view
    output logic ready
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] cs_s, sck_s, si_s;
    logic cs_d, sck_d;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_s <= 2'b11;
            sck_s <= 2'b00;
            si_s <= 2'b00;
            cs_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_s <= {cs_s[0], cs_n};
            sck_s <= {sck_s[0], sck};
            si_s <= {si_s[0], si};
            cs_d <= cs_s[1];
            sck_d <= sck_s[1];
        end
    end
    wire logic sel = ~cs_s[1];
    wire logic rise = sel & sck_s[1] & ~sck_d;
    wire logic fall = sel & ~sck_s[1] & sck_d;
    wire logic cs_rise = cs_s[1] & ~cs_d;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] user_mem [0:flash_seq_pkg::user_bytes-1];
    logic [7:0] sram [0:flash_seq_pkg::buf_bytes-1];
    logic [7:0] page_sum [0:flash_seq_pkg::pages-1];

    // ----------------------------------------
    // Frame decode
    // ----------------------------------------
    logic [15:0] bit_cnt, next_bit_cnt;
    logic [7:0] shreg, next_shreg, opcode, next_opcode;
    logic [23:0] addr, next_addr;
    logic [5:0] wptr, next_wptr;
    logic got_data, next_got_data;
    logic [7:0] out_byte, next_out_byte;
    logic [6:0] rptr, next_rptr;
    logic next_so, next_so_oe_n;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [7:0] status_byte;
    logic [7:0] rd_byte;
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_opcode = opcode;
        next_addr = addr;
        next_wptr = wptr;
        next_got_data = got_data;
        next_out_byte = out_byte;
        next_rptr = rptr;
        next_so = so;
        next_so_oe_n = so_oe_n;
        wr_en = 1'b0;
        wr_byte = {shreg[6:0], si_s[1]};
        // The factory half is derived from the seed, so no command has a path that could change it.
        rd_byte = rptr[6] ? (factory_id_seed ^ {1'b0, rptr}) : user_mem[rptr[5:0]];
        if (!sel) begin
            next_bit_cnt = 16'h0000;
            next_wptr = 6'h00;
            next_rptr = 7'h00;
            next_so_oe_n = 1'b1;
        end else if (rise) begin
            next_shreg = wr_byte;
            next_bit_cnt = bit_cnt + 16'h0001;
            if (bit_cnt == 16'h0007) begin
                next_opcode = wr_byte;
            end else if (bit_cnt >= 16'h0008 && bit_cnt < 16'h0020) begin
                next_addr = {addr[22:0], si_s[1]};
            end
            if (bit_cnt >= 16'h001F && bit_cnt[2:0] == 3'h7 && opcode == flash_seq_pkg::op_sec_prog) begin
                if (bit_cnt > 16'h001F) begin
                    wr_en = 1'b1;
                    next_wptr = wptr + 6'h01;
                    next_got_data = 1'b1;
                end
            end
        end else if (fall) begin
            if (bit_cnt >= 16'h0008 && bit_cnt[2:0] == 3'h0) begin
                if (opcode == flash_seq_pkg::op_status) begin
                    next_out_byte = status_byte;
                end else if (opcode == flash_seq_pkg::op_sec_read && bit_cnt >= 16'h0020) begin
                    next_out_byte = rd_byte;
                    next_rptr = rptr + 7'h01;
                end
            end
            if (bit_cnt >= 16'h0008 && (opcode == flash_seq_pkg::op_status ||
                (opcode == flash_seq_pkg::op_sec_read && bit_cnt >= 16'h0020))) begin
                next_so_oe_n = 1'b0;
                if (bit_cnt[2:0] == 3'h0) begin
                    next_so = (opcode == flash_seq_pkg::op_status) ? status_byte[7] : rd_byte[7];
                end else begin
                    next_so = out_byte[3'h7 - bit_cnt[2:0]];
                end
            end
        end
        if (cs_rise) begin
            next_got_data = 1'b0;
        end
    end

    // ----------------------------------------
    // Self-timed jobs
    // ----------------------------------------
    flash_seq_pkg::op_state_type state, next_state;
    flash_seq_pkg::job_type job, next_job;
    logic [flash_seq_pkg::timer_width-1:0] timer, next_timer;
    logic user_done, next_user_done;
    logic comp_flag, next_comp_flag;
    logic [8:0] page_idx;
    logic [7:0] buf_sum;
    logic [8:0] job_page, next_job_page;
    logic finish;

    // Index position depends on page size format.
    function automatic logic [8:0] page_of(input logic [23:0] a, input logic bin);
        page_of = bin ? a[16:8] : a[17:9];
    endfunction

    assign page_idx = page_of(addr, binary_pages);
    assign buf_sum = sram[0];
    assign status_byte = {state == flash_seq_pkg::st_idle, comp_flag,
                          flash_seq_pkg::density_code, 1'b0, binary_pages};
    assign finish = (state == flash_seq_pkg::st_busy) && (timer == '0);

    always_comb begin
        next_state = state;
        next_job = job;
        next_timer = timer;
        next_user_done = user_done;
        next_comp_flag = comp_flag;
        next_job_page = job_page;
        if (state == flash_seq_pkg::st_idle && cs_rise && bit_cnt >= 16'h0020) begin
            next_state = flash_seq_pkg::st_busy;
            next_job_page = page_idx;
            case (opcode)
                flash_seq_pkg::op_sec_prog: begin
                    next_job = (got_data && !user_done) ? flash_seq_pkg::job_sec : flash_seq_pkg::job_none;
                    next_timer = flash_seq_pkg::timer_width'(flash_seq_pkg::program_cycles);
                end
                flash_seq_pkg::op_xfer: begin
                    next_job = flash_seq_pkg::job_xfer;
                    next_timer = flash_seq_pkg::timer_width'(flash_seq_pkg::transfer_cycles);
                end
                flash_seq_pkg::op_comp: begin
                    next_job = flash_seq_pkg::job_comp;
                    next_timer = flash_seq_pkg::timer_width'(flash_seq_pkg::compare_cycles);
                end
                flash_seq_pkg::op_rewrite: begin
                    next_job = flash_seq_pkg::job_rewrite;
                    next_timer = flash_seq_pkg::timer_width'(flash_seq_pkg::page_program_cycles);
                end
                default: begin
                    next_state = flash_seq_pkg::st_idle;
                end
            endcase
        end else if (state == flash_seq_pkg::st_busy) begin
            next_timer = timer - 1'b1;
            if (finish) begin
                next_state = flash_seq_pkg::st_idle;
                if (job == flash_seq_pkg::job_sec) begin
                    next_user_done = 1'b1;
                end
                if (job == flash_seq_pkg::job_comp) begin
                    next_comp_flag = page_sum[job_page] != buf_sum;
                end
                next_job = flash_seq_pkg::job_none;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bit_cnt <= 16'h0000;
            shreg <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
            wptr <= 6'h00;
            got_data <= 1'b0;
            out_byte <= 8'h00;
            rptr <= 7'h00;
            so <= 1'b0;
            so_oe_n <= 1'b1;
            state <= flash_seq_pkg::st_idle;
            job <= flash_seq_pkg::job_none;
            timer <= '0;
            user_done <= 1'b0;
            comp_flag <= 1'b0;
            job_page <= 9'h000;
            ready <= 1'b1;
        end else begin
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            opcode <= next_opcode;
            addr <= next_addr;
            wptr <= next_wptr;
            got_data <= next_got_data;
            out_byte <= next_out_byte;
            rptr <= next_rptr;
            so <= next_so;
            so_oe_n <= next_so_oe_n;
            state <= next_state;
            job <= next_job;
            timer <= next_timer;
            user_done <= next_user_done;
            comp_flag <= next_comp_flag;
            job_page <= next_job_page;
            ready <= (next_state == flash_seq_pkg::st_idle);
        end
    end

    // Arrays carry no reset; their content is data, not control.
    // Bytes land in the buffer while shifting and move to the user half at the end,
    // so an aborted or refused program never touches the security area.
    always_ff @(posedge clk_sys) begin
        if (wr_en && !user_done && state == flash_seq_pkg::st_idle) begin
            sram[wptr] <= wr_byte;
        end
        if (finish && job == flash_seq_pkg::job_sec) begin
            for (int i = 0; i < flash_seq_pkg::user_bytes; i++) begin
                user_mem[i] <= sram[i];
            end
        end
        if (finish && (job == flash_seq_pkg::job_xfer || job == flash_seq_pkg::job_rewrite)) begin
            sram[0] <= page_sum[job_page];
        end
    end

    // The page store is a constant of this model; only its low index byte tells pages apart.
    generate
        for (genvar p = 0; p < flash_seq_pkg::pages; p++) begin : g_page
            assign page_sum[p] = 8'(p);
        end
    endgenerate
endmodule

/* rtl/flash_seq_pkg.sv */
// Constants for the security area and page maintenance command handler.
// Assumes a serial host in mode 0 or 3, sampled by a much faster system clock.
// How it works
// - 128-byte security area, user half, factory half.
// - User half programmable once, later attempts rejected.
// - Factory half fixed, never modified.
// - User half programs without prior erase.
// - Chip select rise starts timed program, busy.
// - Bytes not received are left undefined.
// - Byte pointer wraps after 64 bytes.
// - Program command overwrites the SRAM buffer (here only while idle and the user half is not yet programmed).
// - Opcode 77, three dummies, data from byte 0.
// - Past byte 127 output is undefined.
// - Chip select rise ends read, output released.
// - Page operation starts at chip select rise.
// - Status readable during transfer, shows completion.
// - Compare shows busy, result into bit six.
// - Rewrite copies page then reprograms it, busy.
// - Status bit seven: one ready, zero busy.
// - Compare bit zero on match, one otherwise.
// - Opcode D7 streams status MSB first repeatedly.
// - Status bit zero reports page size.
package flash_seq_pkg;
    localparam logic [7:0] op_sec_prog = 8'h9B;
    localparam logic [7:0] op_sec_read = 8'h77;
    localparam logic [7:0] op_xfer = 8'h53;
    localparam logic [7:0] op_comp = 8'h60;
    localparam logic [7:0] op_rewrite = 8'h58;
    localparam logic [7:0] op_status = 8'hD7;
    localparam int sec_bytes = 128;
    localparam int user_bytes = 64;
    localparam int buf_bytes = 264;
    localparam int pages = 512;
    localparam logic [3:0] density_code = 4'h3;
    localparam int status_ready_bit = 7;
    localparam int status_comp_bit = 6;
    localparam int status_size_bit = 0;
    // Times in nanoseconds; plain defaults, no part figures are known.
    localparam int clk_period_ns = 4;
    localparam int program_time_ns = 4000;
    localparam int transfer_time_ns = 400;
    localparam int compare_time_ns = 400;
    localparam int page_program_time_ns = 8000;
    localparam int program_cycles = program_time_ns / clk_period_ns;
    localparam int transfer_cycles = transfer_time_ns / clk_period_ns;
    localparam int compare_cycles = compare_time_ns / clk_period_ns;
    localparam int page_program_cycles = page_program_time_ns / clk_period_ns;
    localparam int timer_width = 16;
    localparam logic [7:0] factory_seed = 8'hA5;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_busy = 2'b01
    } op_state_type;
    typedef enum logic [2:0] {
        job_none = 3'h0,
        job_sec = 3'h1,
        job_xfer = 3'h2,
        job_comp = 3'h3,
        job_rewrite = 3'h4
    } job_type;
endpackage

/* tb/flash_host_model.sv */
// Host serial controller model, mode 0, clock still between frames.
// Assumes clk_sys runs at 4 ns; half sets the serial half period.
`timescale 1ns/1ps
module flash_host_model (
    // System
    input wire logic clk_sys,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    int half = 20;
    // The bench runs far fewer than 20000 page operations, so no refresh is owed.
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b1;
    end
    task automatic frame_start();
        @(negedge clk_sys);
        cs_n = 1'b0;
    endtask
    // Data leaves MSB first while sck is low and is taken at the rise.
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int b = 7; b >= 0; b--) begin
            si = tx[b];
            repeat (half) @(negedge clk_sys);
            sck = 1'b1;
            rx[b] = so;
            repeat (half) @(negedge clk_sys);
            sck = 1'b0;
        end
    endtask
    // Select rises to launch the job; si is left changed so nothing stale is seen.
    task automatic frame_end();
        repeat (half) @(negedge clk_sys);
        cs_n = 1'b1;
        si = ~si;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

/* tb/flash_seq_asserts.sv */
// Pin checker for the flash command handler.
// Assumes it is bound to flash_seq and sees only its ports.
`timescale 1ns/1ps
module flash_seq_asserts (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic ready
);
    localparam int min_busy = 90;
    localparam int max_busy = 2100;
    int busy_cnt;
    int fall_age;
    logic sck_d;
    // ---
    // Helpers
    // ---
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_cnt <= 0;
            fall_age <= 99;
            sck_d <= 1'b0;
        end else begin
            busy_cnt <= ready ? 0 : busy_cnt + 1;
            fall_age <= (sck_d && !sck) ? 0 : (fall_age < 99 ? fall_age + 1 : fall_age);
            sck_d <= sck;
        end
    end
    sequence deselected;
        cs_n [*6];
    endsequence
    sequence busy_run;
        !ready [*8];
    endsequence
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_release_when_idle: assert property (deselected |-> so_oe_n)
        else $error("so driven while deselected");
    a_release_after_rise: assert property ($rose(so_oe_n) |-> $past(cs_n, 2))
        else $error("so released without select rise");
    a_drive_needs_select: assert property ($fell(so_oe_n) |-> !cs_n)
        else $error("so driven while deselected");
    a_job_after_select: assert property ($fell(ready) |-> cs_n && $past(cs_n, 2))
        else $error("job started without select rise");
    a_busy_min_run: assert property ($fell(ready) |-> busy_run)
        else $error("busy pulse too short");
    a_busy_min_time: assert property ($rose(ready) |-> busy_cnt >= min_busy)
        else $error("job ended too early");
    a_busy_max_time: assert property (busy_cnt <= max_busy)
        else $error("job ran too long");
    a_so_after_fall: assert property (!so_oe_n && $changed(so) |-> fall_age <= 10)
        else $error("so changed away from clock fall");
endmodule
bind flash_seq flash_seq_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck),
    .so(so), .so_oe_n(so_oe_n), .ready(ready));

/* tb/flash_seq_test.sv */
// Self-checking bench for the flash command handler.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
module flash_seq_test;
    localparam logic [7:0] idle_st = {1'b1, 1'b0, flash_seq_pkg::density_code, 2'b00};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    localparam logic [23:0] near_adr = {6'h00, 9'h105, 9'h000};
    localparam logic [23:0] far_adr = {6'h3F, 9'h105, 9'h1FF};
    logic cs_n, sck, si, so, so_oe_n, ready;
    logic so2, so_oe_n2, ready2;
    logic pick = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    logic [7:0] rx;
    logic [7:0] img [66];
    logic [7:0] fact [2];
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    flash_seq DUT (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe_n(so_oe_n), .ready(ready));
    // A second handler decodes the same frames with binary page addressing.
    flash_seq #(.binary_pages(1'b1)) DUT2 (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .so(so2), .so_oe_n(so_oe_n2), .ready(ready2));
    // A released output shows the inverse of its last value, so a late drive is caught.
    flash_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si),
        .so(pick ? (so_oe_n2 ? ~so2 : so2) : (so_oe_n ? ~so : so)));
    // ---
    // Tasks
    // ---
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 3000 && ready !== 1'b1; i++) @(negedge clk_sys);
        if (ready !== 1'b1) begin
            $display("[FAIL] ready expected 1 seen %b", ready);
            n_errors++;
            summarize();
        end
    endtask
    task automatic job(input logic busy);
        check("ready at start", {7'h00, ~busy}, {7'h00, ready});
        check("ready2 at start", {7'h00, ~busy}, {7'h00, ready2});
        wait_ready();
    endtask
    task automatic status(output logic [7:0] s, input logic rep);
        host.frame_start();
        host.shift(flash_seq_pkg::op_status, rx);
        host.shift(8'hFF, s);
        if (rep) begin
            host.shift(8'hFF, rx);
            check("status repeat", s, rx);
        end
        host.frame_end();
    endtask
    // Reads status from both handlers; binary addressing also reports bit zero set.
    task automatic status_pair(input string what, input logic comp_std, input logic comp_bin);
        logic [7:0] s;
        pick = 1'b0;
        status(s, 1'b1);
        check(what, idle_st | {1'b0, comp_std, 6'h00}, s);
        pick = 1'b1;
        status(s, 1'b1);
        check({what, " binary"}, idle_st | {1'b0, comp_bin, 5'h00, 1'b1}, s);
        pick = 1'b0;
    endtask
    // The far address sets every don't-care bit: standard decoding must ignore them,
    // while binary decoding lands one page above the near address.
    task automatic page_op(input logic [7:0] op, input logic [23:0] a);
        host.frame_start();
        host.shift(op, rx);
        for (int i = 2; i >= 0; i--) host.shift(a[i*8+:8], rx);
        host.frame_end();
        job(1'b1);
    endtask
    task automatic send_prog(input int n, input logic [7:0] base);
        host.frame_start();
        host.shift(flash_seq_pkg::op_sec_prog, rx);
        repeat (3) host.shift(8'h00, rx);
        for (int k = 0; k < n; k++) host.shift(k == 64 ? 8'hC3 : base + k[7:0], rx);
        host.frame_end();
    endtask
    // Reads the user half and two factory bytes; a full read would nearly double each read frame.
    task automatic sec_read();
        host.frame_start();
        host.shift(flash_seq_pkg::op_sec_read, rx);
        repeat (3) host.shift(8'h00, rx);
        for (int i = 0; i < 66; i++) host.shift(8'h00, img[i]);
        host.frame_end();
        check("so released", 8'h01, {7'h00, so_oe_n});
        for (int i = 0; i < 64; i++) check("user byte", i == 0 ? 8'hC3 : 8'h10 + i[7:0], img[i]);
    endtask
    // ---
    // Scenarios
    // ---
    task automatic idle_and_short();
        logic [7:0] s;
        status(s, 1'b1);
        check("status idle", idle_st & 8'hBF, s & 8'hBF);
        host.frame_start();
        host.shift(flash_seq_pkg::op_xfer, rx);
        host.shift(8'h00, rx);
        host.frame_end();
        job(1'b0);
    endtask
    task automatic page_jobs();
        page_op(flash_seq_pkg::op_xfer, near_adr);
        page_op(flash_seq_pkg::op_comp, far_adr);
        status_pair("compare match", 1'b0, 1'b1);
        page_op(flash_seq_pkg::op_rewrite, far_adr);
        page_op(flash_seq_pkg::op_comp, far_adr);
        status_pair("compare after rewrite", 1'b0, 1'b0);
    endtask
    task automatic sec_jobs();
        logic [7:0] s;
        send_prog(65, 8'h10);
        status(s, 1'b0);
        check("busy bit", 8'h00, s & 8'h80);
        wait_ready();
        sec_read();
        fact[0] = img[64];
        fact[1] = img[65];
        send_prog(2, 8'h55);
        job(1'b1);
        sec_read();
        check("factory byte 64", fact[0], img[64]);
        check("factory byte 65", fact[1], img[65]);
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        idle_and_short();
        page_jobs();
        sec_jobs();
        summarize();
    end
endmodule
